// file: src/ipr_regs.v
// ipr_regs.v: five 16-bit priority control registers behind apb
// assumes: apb master on I_CLK_SYS; arbiter samples the level outputs
//
// Function
// - code 111 gives priority level 7
// - code 001 gives level 1, linear
// - code 000 disables the source
// - unimplemented bits read zero, ignore writes
// - every field resets to 100
// - ctrl 0: timer1, outcmp1, incap1, ext irq0
// - ctrl 1: timer2, outcmp2, incap2, dma0
// - ctrl 2: uart1 rx, spi1 event, error, timer3
// - ctrl 3: dma1, adc1, uart1 tx only
// - ctrl 4: change notify, comparator, i2c1 pair
`timescale 1ns/1ps
`include "ipr_defs.vh"
module ipr_regs #(
  parameter ADDR_W = 12
) (
  // clock and reset
  input wire I_CLK_SYS,
  input wire I_RSTN,
  // apb slave
  input wire i_PSEL,
  input wire i_PENABLE,
  input wire i_PWRITE,
  input wire [ADDR_W-1:0] i_PADDR,
  input wire [31:0] i_PWDATA,
  input wire [3:0] i_PSTRB,
  output wire o_PREADY,
  output reg [31:0] o_PRDATA,
  output wire o_PSLVERR,
  // priority levels to the arbiter
  output wire [2:0] o_TIMER1_PRIORITY,
  output wire [2:0] o_OUTCMP1_PRIORITY,
  output wire [2:0] o_INCAP1_PRIORITY,
  output wire [2:0] o_EXT_IRQ0_PRIORITY,
  output wire [2:0] o_TIMER2_PRIORITY,
  output wire [2:0] o_OUTCMP2_PRIORITY,
  output wire [2:0] o_INCAP2_PRIORITY,
  output wire [2:0] o_DMA_CH0_PRIORITY,
  output wire [2:0] o_UART1_RX_PRIORITY,
  output wire [2:0] o_SPI1_EVENT_PRIORITY,
  output wire [2:0] o_SPI1_ERROR_PRIORITY,
  output wire [2:0] o_TIMER3_PRIORITY,
  output wire [2:0] o_DMA_CH1_PRIORITY,
  output wire [2:0] o_ADC1_DONE_PRIORITY,
  output wire [2:0] o_UART1_TX_PRIORITY,
  output wire [2:0] o_CHANGE_NOTIFY_PRIORITY,
  output wire [2:0] o_COMPARATOR_PRIORITY,
  output wire [2:0] o_I2C1_MASTER_PRIORITY,
  output wire [2:0] o_I2C1_SLAVE_PRIORITY,
  // per-source enables, 19 sources in field order
  output wire [18:0] o_SOURCE_ENABLE
);
  // ==========================================================
  // helpers
  // register index from an address, 7 when unmapped
  function [2:0] reg_index;
    input [ADDR_W-1:0] addr;
    begin
      case (addr)
        `IPR_OFS_CTRL0: reg_index = 3'h0;
        `IPR_OFS_CTRL1: reg_index = 3'h1;
        `IPR_OFS_CTRL2: reg_index = 3'h2;
        `IPR_OFS_CTRL3: reg_index = 3'h3;
        `IPR_OFS_CTRL4: reg_index = 3'h4;
        default: reg_index = 3'h7;
      endcase
    end
  endfunction

  // writable-bit mask per register
  function [15:0] reg_mask;
    input [2:0] idx;
    begin
      if (idx == 3'h3) begin
        reg_mask = `IPR_MASK_CTRL3;
      end else begin
        reg_mask = `IPR_MASK_FULL;
      end
    end
  endfunction

  // ==========================================================
  // storage
  reg [15:0] priority_ctrl_0;
  reg [15:0] priority_ctrl_1;
  reg [15:0] priority_ctrl_2;
  reg [15:0] priority_ctrl_3;
  reg [15:0] priority_ctrl_4;
  wire [2:0] idx; // decoded register index
  wire acc_phase; // apb access phase
  wire wr_en; // write takes effect this edge
  wire [15:0] wmask; // implemented bits of the target
  wire [15:0] lane_mask; // byte strobes widened to bits
  wire [15:0] next_val; // merged write value

  assign idx = reg_index(i_PADDR);
  assign acc_phase = i_PSEL & i_PENABLE;
  // zero-wait slave: always ready in the access phase
  assign o_PREADY = 1'b1;
  // unmapped addresses answer with an error, never a silent ok
  assign o_PSLVERR = acc_phase & (idx == 3'h7);
  assign wr_en = acc_phase & i_PWRITE & (idx != 3'h7);
  assign wmask = reg_mask(idx);
  assign lane_mask = {{8{i_PSTRB[1]}}, {8{i_PSTRB[0]}}};

  // ==========================================================
  // write merge
  // unimplemented bits are forced to zero so they can never hold a one
  reg [15:0] cur_val;
  always @* begin
    case (idx)
      3'h0: cur_val = priority_ctrl_0;
      3'h1: cur_val = priority_ctrl_1;
      3'h2: cur_val = priority_ctrl_2;
      3'h3: cur_val = priority_ctrl_3;
      3'h4: cur_val = priority_ctrl_4;
      default: cur_val = 16'h0000;
    endcase
  end
  assign next_val = ((i_PWDATA[15:0] & lane_mask) |
                     (cur_val & ~lane_mask)) & wmask;

  // ==========================================================
  // register update
  // reset loads 100 in every field, level four
  always @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      priority_ctrl_0 <= `IPR_RST_FULL;
      priority_ctrl_1 <= `IPR_RST_FULL;
      priority_ctrl_2 <= `IPR_RST_FULL;
      priority_ctrl_3 <= `IPR_RST_CTRL3;
      priority_ctrl_4 <= `IPR_RST_FULL;
    end else if (wr_en) begin
      // write lands on the access-phase edge, visible next cycle
      case (idx)
        3'h0: priority_ctrl_0 <= next_val;
        3'h1: priority_ctrl_1 <= next_val;
        3'h2: priority_ctrl_2 <= next_val;
        3'h3: priority_ctrl_3 <= next_val;
        3'h4: priority_ctrl_4 <= next_val;
        default: priority_ctrl_0 <= priority_ctrl_0;
      endcase
    end
  end

  // ==========================================================
  // read data
  // registered so data outputs come from flip-flops; the setup cycle
  // gives one edge to load it before the access phase samples it
  always @(posedge I_CLK_SYS or negedge I_RSTN) begin
    if (!I_RSTN) begin
      o_PRDATA <= 32'h00000000;
    end else if (i_PSEL & ~i_PENABLE & ~i_PWRITE) begin
      o_PRDATA <= {16'h0000, cur_val};
    end else if (acc_phase) begin
      o_PRDATA <= 32'h00000000;
    end
  end

  // ==========================================================
  // field fan-out
  // all 20 slots laid out flat, slot 3 of ctrl 3 is unused
  wire [79:0] all_regs;
  wire [59:0] levels;
  wire [19:0] enables;
  assign all_regs = {priority_ctrl_4, priority_ctrl_3, priority_ctrl_2,
                     priority_ctrl_1, priority_ctrl_0};
  genvar g;
  generate
    for (g = 0; g < 20; g = g + 1) begin : g_fld
      // fields sit at nibble boundaries, bit 3 of each nibble unused
      ipr_field_dec u_dec (
        .i_field (all_regs[4*g+2:4*g]),
        .o_enable (enables[g]),
        .o_level (levels[3*g+2:3*g])
      );
    end
  endgenerate

  // slot s of register r is index 4*r + s; slot 3 is bits 14-12
  assign o_TIMER1_PRIORITY = levels[3*3+2:3*3];
  assign o_OUTCMP1_PRIORITY = levels[3*2+2:3*2];
  assign o_INCAP1_PRIORITY = levels[3*1+2:3*1];
  assign o_EXT_IRQ0_PRIORITY = levels[2:0];
  assign o_TIMER2_PRIORITY = levels[3*7+2:3*7];
  assign o_OUTCMP2_PRIORITY = levels[3*6+2:3*6];
  assign o_INCAP2_PRIORITY = levels[3*5+2:3*5];
  assign o_DMA_CH0_PRIORITY = levels[3*4+2:3*4];
  assign o_UART1_RX_PRIORITY = levels[3*11+2:3*11];
  assign o_SPI1_EVENT_PRIORITY = levels[3*10+2:3*10];
  assign o_SPI1_ERROR_PRIORITY = levels[3*9+2:3*9];
  assign o_TIMER3_PRIORITY = levels[3*8+2:3*8];
  assign o_DMA_CH1_PRIORITY = levels[3*14+2:3*14];
  assign o_ADC1_DONE_PRIORITY = levels[3*13+2:3*13];
  assign o_UART1_TX_PRIORITY = levels[3*12+2:3*12];
  assign o_CHANGE_NOTIFY_PRIORITY = levels[3*19+2:3*19];
  assign o_COMPARATOR_PRIORITY = levels[3*18+2:3*18];
  assign o_I2C1_MASTER_PRIORITY = levels[3*17+2:3*17];
  assign o_I2C1_SLAVE_PRIORITY = levels[3*16+2:3*16];
  // enables skip the dead slot 3 of ctrl 3, index 15
  assign o_SOURCE_ENABLE = {enables[19:16], enables[14:0]};
endmodule // ipr_regs

// file: inc/ipr_defs.vh
// ipr_defs.vh: constants for the interrupt priority register block
// assumes: included by bare name from the design files
`ifndef IPR_DEFS_VH
`define IPR_DEFS_VH
// ==========================================================
// register byte offsets on the apb bus
`define IPR_OFS_CTRL0 12'h000
`define IPR_OFS_CTRL1 12'h004
`define IPR_OFS_CTRL2 12'h008
`define IPR_OFS_CTRL3 12'h00C
`define IPR_OFS_CTRL4 12'h010
// ==========================================================
// field geometry
`define IPR_NUM_REGS 5
`define IPR_FIELD_W 3
`define IPR_FLD3_LSB 12
`define IPR_FLD2_LSB 8
`define IPR_FLD1_LSB 4
`define IPR_FLD0_LSB 0
// ==========================================================
// reset and masks
`define IPR_FIELD_RST 3'h4
`define IPR_RST_FULL 16'h4444
`define IPR_RST_CTRL3 16'h0444
`define IPR_MASK_FULL 16'h7777
`define IPR_MASK_CTRL3 16'h0777
`define IPR_PRIO_OFF 3'h0
`endif

// file: src/ipr_field_dec.v
// ipr_field_dec.v: turns one priority field into an enable and a level
// assumes: field comes straight from a register on the same clock
`timescale 1ns/1ps
`include "ipr_defs.vh"
module ipr_field_dec (
  // field in
  input wire [2:0] i_field,
  // decoded out
  output wire o_enable,
  output wire [2:0] o_level
);
  // ==========================================================
  // decode
  // zero code means the source is off; otherwise code is the level
  assign o_enable = (i_field != `IPR_PRIO_OFF);
  assign o_level = i_field;
endmodule // ipr_field_dec

// file: test/ipr_regs_asserts.sv
// ipr_regs_asserts.sv: port checks of the priority registers
// assumes: bound onto ipr_regs, one clock, apb master obeys protocol
`timescale 1ns/1ps
module ipr_regs_chk #(parameter ADDR_W = 12) (
  // clock, reset and apb side
  input wire I_CLK_SYS,
  input wire I_RSTN,
  input wire i_PSEL,
  input wire i_PENABLE,
  input wire i_PWRITE,
  input wire [ADDR_W-1:0] i_PADDR,
  input wire [31:0] i_PWDATA,
  input wire [3:0] i_PSTRB,
  input wire [31:0] o_PRDATA,
  // levels and enables to the arbiter
  input wire [2:0] o_TIMER1_PRIORITY,
  input wire [2:0] o_DMA_CH0_PRIORITY,
  input wire [2:0] o_TIMER3_PRIORITY,
  input wire [2:0] o_UART1_TX_PRIORITY,
  input wire [2:0] o_CHANGE_NOTIFY_PRIORITY,
  input wire [18:0] o_SOURCE_ENABLE
);
  // ====
  // write lands on the access edge, so fields move one edge later
  wire wr = i_PSEL && i_PENABLE && i_PWRITE;
  default clocking @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RSTN);
  property p_rst; !$past(I_RSTN) |->
    o_SOURCE_ENABLE == 19'h7FFFF && o_TIMER1_PRIORITY == 3'h4; endproperty
  a_rst: assert property (p_rst) else $error("reset level");
  property p_hi; (o_PRDATA & 32'hFFFF8888) == 32'h0; endproperty
  a_hi: assert property (p_hi) else $error("reserved bit set");
  property p_t1; wr && i_PADDR == 12'h000 && i_PSTRB[1] |=>
    o_TIMER1_PRIORITY == $past(i_PWDATA[14:12]); endproperty
  a_t1: assert property (p_t1) else $error("timer1 field");
  property p_d0; wr && i_PADDR == 12'h004 && i_PSTRB[0] |=>
    o_DMA_CH0_PRIORITY == $past(i_PWDATA[2:0]); endproperty
  a_d0: assert property (p_d0) else $error("dma0 field");
  property p_t3; wr && i_PADDR == 12'h008 && i_PSTRB[0] |=>
    o_TIMER3_PRIORITY == $past(i_PWDATA[2:0]); endproperty
  a_t3: assert property (p_t3) else $error("timer3 field");
  property p_tx; wr && i_PADDR == 12'h00C && i_PSTRB[0] |=>
    o_UART1_TX_PRIORITY == $past(i_PWDATA[2:0]); endproperty
  a_tx: assert property (p_tx) else $error("uart1 tx field");
  property p_cn; wr && i_PADDR == 12'h010 && i_PSTRB[1] |=>
    o_CHANGE_NOTIFY_PRIORITY == $past(i_PWDATA[14:12]); endproperty
  a_cn: assert property (p_cn) else $error("change notify");
  property p_en; o_SOURCE_ENABLE[3] == |o_TIMER1_PRIORITY
    && o_SOURCE_ENABLE[18] == |o_CHANGE_NOTIFY_PRIORITY; endproperty
  a_en: assert property (p_en) else $error("enable mismatch");
  // main scenarios reached
  c_w3: cover property (wr && i_PADDR == 12'h00C);
  c_off: cover property (o_SOURCE_ENABLE == 19'h0);
  c_t7: cover property (o_TIMER1_PRIORITY == 3'h7);
endmodule // ipr_regs_chk
bind ipr_regs ipr_regs_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// file: test/interrupt_priority_regs_bench.sv
// interrupt_priority_regs_bench.sv: apb bench for the priority registers
// assumes: ipr_regs and its checker compiled before this file
`timescale 1ns/1ps
module interrupt_priority_regs_bench;
  // ====
  // design ports, shadow registers and expected-read queue
  logic I_CLK_SYS = 0, I_RSTN = 0, i_PSEL = 0, i_PENABLE = 0, i_PWRITE = 0;
  logic [11:0] i_PADDR = 0;
  logic [31:0] i_PWDATA = 0;
  logic [3:0] i_PSTRB = 0;
  wire o_PREADY, o_PSLVERR;
  wire [31:0] o_PRDATA;
  wire [18:0] o_SOURCE_ENABLE;
  wire [2:0] o_TIMER1_PRIORITY, o_OUTCMP1_PRIORITY, o_INCAP1_PRIORITY,
    o_EXT_IRQ0_PRIORITY, o_TIMER2_PRIORITY, o_OUTCMP2_PRIORITY,
    o_INCAP2_PRIORITY, o_DMA_CH0_PRIORITY, o_UART1_RX_PRIORITY,
    o_SPI1_EVENT_PRIORITY, o_SPI1_ERROR_PRIORITY, o_TIMER3_PRIORITY,
    o_DMA_CH1_PRIORITY, o_ADC1_DONE_PRIORITY, o_UART1_TX_PRIORITY,
    o_CHANGE_NOTIFY_PRIORITY, o_COMPARATOR_PRIORITY,
    o_I2C1_MASTER_PRIORITY, o_I2C1_SLAVE_PRIORITY;
  logic [15:0] sh[5], m;
  logic [32:0] q[$];
  logic [18:0] en;
  logic [56:0] lv;
  int num_errors = 0, checked = 0, n, r, c;
  initial forever #20 I_CLK_SYS = ~I_CLK_SYS;
  ipr_regs uut (.*);
  task check(input [32:0] got, input [32:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task report_and_stop;
    if (num_errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // one apb transfer; waits for pready under a bound
  task xfer(input bit w, input int r, input [31:0] d, input [3:0] s);
    @(posedge I_CLK_SYS);
    i_PSEL <= 1;
    i_PWRITE <= w;
    i_PADDR <= 12'(r * 4);
    i_PWDATA <= d;
    i_PSTRB <= s;
    @(posedge I_CLK_SYS);
    i_PENABLE <= 1;
    n = 0;
    do begin
      @(posedge I_CLK_SYS);
      n++;
    end while (o_PREADY !== 1'b1 && n < 9);
    if (o_PREADY !== 1'b1) begin
      num_errors++;
      report_and_stop;
    end else begin
      i_PSEL <= 0;
      i_PENABLE <= 0;
    end
  endtask
  // shadow keeps only implemented bits of strobed lanes
  task wr(input int r, input [31:0] d, input [3:0] s);
    m = r == 3 ? 16'h0777 : 16'h7777;
    if (r < 5 && s[0]) sh[r][7:0] = d[7:0] & m[7:0];
    if (r < 5 && s[1]) sh[r][15:8] = d[15:8] & m[15:8];
    xfer(1, r, d, s);
  endtask
  task rd(input int r);
    q.push_back({r > 4, r < 5 ? {16'h0, sh[r]} : 32'h0});
    xfer(0, r, $urandom, 4'h0);
  endtask
  // enables in register order, ctrl 3 has no top field
  task chk_en;
    n = 0;
    @(negedge I_CLK_SYS);
    // every level output in enable order, low source first
    lv = {o_CHANGE_NOTIFY_PRIORITY, o_COMPARATOR_PRIORITY,
      o_I2C1_MASTER_PRIORITY, o_I2C1_SLAVE_PRIORITY, o_DMA_CH1_PRIORITY,
      o_ADC1_DONE_PRIORITY, o_UART1_TX_PRIORITY, o_UART1_RX_PRIORITY,
      o_SPI1_EVENT_PRIORITY, o_SPI1_ERROR_PRIORITY, o_TIMER3_PRIORITY,
      o_TIMER2_PRIORITY, o_OUTCMP2_PRIORITY, o_INCAP2_PRIORITY,
      o_DMA_CH0_PRIORITY, o_TIMER1_PRIORITY, o_OUTCMP1_PRIORITY,
      o_INCAP1_PRIORITY, o_EXT_IRQ0_PRIORITY};
    for (int i = 0; i < 20; i++)
      if (i != 15) begin
        en[n] = |sh[i / 4][i % 4 * 4 +: 3];
        check(lv[3 * n +: 3], sh[i / 4][i % 4 * 4 +: 3]);
        n++;
      end
    check(o_SOURCE_ENABLE, en);
    check(o_UART1_TX_PRIORITY, sh[3][2:0]);
  endtask
  task rst;
    I_RSTN <= 0;
    repeat (8) @(posedge I_CLK_SYS);
    I_RSTN <= 1;
    foreach (sh[i]) sh[i] = i == 3 ? 16'h0444 : 16'h4444;
    for (int i = 0; i < 6; i++) rd(i);
    chk_en;
  endtask
  // read results compared oldest first
  always @(posedge I_CLK_SYS)
    if (I_RSTN && i_PSEL && i_PENABLE && !i_PWRITE && o_PREADY === 1'b1)
      check({o_PSLVERR, o_PRDATA}, q.size() ? q.pop_front() : 33'h1);
  initial begin
    n = $urandom(32'h4e26b185);
    rst;
    for (c = 0; c < 8; c++) begin
      for (r = 0; r < 5; r++)
        wr(r, $urandom & 32'hFFFF8888 | {4{1'b0, c[2:0]}}, 4'hF);
      chk_en;
      for (r = 0; r < 6; r++) rd(r);
    end
    repeat (40) begin
      wr($urandom % 6, $urandom, 4'($urandom));
      rd($urandom % 6);
    end
    chk_en;
    rst;
    report_and_stop;
  end
endmodule // interrupt_priority_regs_bench
